// [core/scc_consts.svh]
// Offsets, field positions, reset values and timing counts for the serial port block
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

// Byte offsets of the registers on the bus
`define SCC_OFF_STATUS_A 5'h00
`define SCC_OFF_CONTROL_B 5'h04
`define SCC_OFF_FRAME 5'h08
`define SCC_OFF_DIV_HIGH 5'h0C
`define SCC_OFF_DIV_LOW 5'h10
`define SCC_OFF_DATA 5'h14

// Status A fields
`define SCC_STA_RX_DONE 7
`define SCC_STA_TX_DONE 6
`define SCC_STA_TX_EMPTY 5
`define SCC_STA_FRAME_ERR 4
`define SCC_STA_OVERRUN 3
`define SCC_STA_PARITY_ERR 2
`define SCC_STA_DOUBLE 1

// Control B fields
`define SCC_CTL_RX_IRQ_EN 7
`define SCC_CTL_TX_IRQ_EN 6
`define SCC_CTL_EMPTY_IRQ_EN 5
`define SCC_CTL_RX_EN 4
`define SCC_CTL_TX_EN 3
`define SCC_CTL_SIZE_HIGH 2
`define SCC_CTL_RX_NINTH 1
`define SCC_CTL_TX_NINTH 0

// Frame format fields
`define SCC_FMT_SYNC 6
`define SCC_FMT_PAR_HI 5
`define SCC_FMT_PAR_LO 4
`define SCC_FMT_STOP 3
`define SCC_FMT_SIZE_HI 2
`define SCC_FMT_SIZE_LO 1
`define SCC_FMT_POL 0

// Reset values
`define SCC_RST_CONTROL_B 8'h00
`define SCC_RST_FRAME 8'h06
`define SCC_RST_DIV_HIGH 4'h0
`define SCC_RST_DIV_LOW 8'h00

// Samples per bit
`define SCC_OS_NORMAL 5'd16
`define SCC_OS_DOUBLE 5'd8
`define SCC_OS_SYNC 5'd2

`endif

// [core/scc_pkg.sv]
// Types shared by the serial port block
package scc_pkg;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } scc_av_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } scc_av_rsp_type;

  typedef enum logic [2:0] {
    SCC_TX_IDLE = 3'b000,
    SCC_TX_DATA = 3'b001,
    SCC_TX_PAR = 3'b010,
    SCC_TX_STOP1 = 3'b011,
    SCC_TX_STOP2 = 3'b100,
    SCC_TX_DONE = 3'b101
  } scc_tx_state_type;

  typedef enum logic [2:0] {
    SCC_RX_IDLE = 3'b000,
    SCC_RX_START = 3'b001,
    SCC_RX_DATA = 3'b010,
    SCC_RX_PAR = 3'b011,
    SCC_RX_STOP = 3'b100
  } scc_rx_state_type;

  typedef struct packed {
    logic [11:0] count;
    logic tick;
  } scc_baud_state_type;

endpackage

// [core/scc_baud_gen.sv]
// Baud prescaler: down counter that ticks once every divisor plus one clocks
`timescale 1ns/100ps
`include "scc_consts.svh"
module scc_baud_gen
  import scc_pkg::*;
#(
  parameter int DIV_WIDTH = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  // Divisor and control
  input wire logic [DIV_WIDTH-1:0] divisor,
  input wire logic reload,
  // Prescaler output
  output logic tick
);

  scc_baud_state_type s_q;
  scc_baud_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (reload) begin
      s_d.count = divisor;
    end else if (s_q.count == '0) begin
      s_d.count = divisor;
      s_d.tick = 1'b1;
    end else begin
      s_d.count = s_q.count - 12'h001;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

// [core/scc_top.sv]
// Serial port channel: registers, frame format, baud timing and serial engines
// Operation
// - receive interrupt needs its enable, global interrupt flag and receive-done flag.
// - transmit interrupt needs its enable, global interrupt flag and transmit-done flag.
// - empty interrupt needs its enable, global interrupt flag and buffer-empty flag.
// - receiver enable starts the receiver and takes the receive pin.
// - clearing receiver enable flushes buffer and error flags.
// - transmitter enable starts the transmitter and takes the transmit pin.
// - transmitter disable waits until shifter and buffer are empty.
// - received ninth bit readable; software reads it before the low byte.
// - mode bit zero is asynchronous, one is synchronous.
// - parity field 00 off, 01 reserved, 10 even, 11 odd.
// - transmitter appends parity; receiver checks it and flags mismatch.
// - stop select gives one or two transmitted stop bits; receiver ignores it.
// - size code 000..011 gives five to eight bits, 111 gives nine.
// - sync polarity zero changes data on rising, samples on falling edge.
// - divisor is twelve bits, high byte holds the top four.
// - writing the divisor low byte reloads the prescaler at once.
// - receive-done flag follows unread data; disabling receiver clears it.
// - double speed bit cuts samples per bit from sixteen to eight.
`timescale 1ns/100ps
`include "scc_consts.svh"
module scc_top
  import scc_pkg::*;
(
  // Clock, reset and enable
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  // Register bus
  input wire scc_av_req_type av_req,
  output scc_av_rsp_type av_rsp,
  // Processor global interrupt flag
  input wire logic global_irq_flag,
  // Interrupt requests
  output logic rx_done_irq,
  output logic tx_done_irq,
  output logic buffer_empty_irq,
  // Serial pins
  input wire logic serial_rx_pin,
  output logic serial_rx_takeover,
  output logic serial_tx_out,
  output logic serial_tx_oe,
  output logic transfer_clock_out,
  output logic transfer_clock_oe
);

  typedef struct packed {
    logic wait_q;
    logic [31:0] rdata;
    logic rd_took;
    logic rx_irq_en;
    logic tx_irq_en;
    logic empty_irq_en;
    logic rx_en;
    logic tx_en_wr;
    logic tx_en;
    logic size_high;
    logic tx_ninth;
    logic [7:0] frame;
    logic double_speed;
    logic [3:0] div_high;
    logic [7:0] div_low;
    logic reload;
    logic [8:0] tx_buf;
    logic tx_empty;
    logic tx_done;
    scc_tx_state_type tx_state;
    logic [8:0] tx_shift;
    logic [3:0] tx_bit;
    logic tx_par;
    logic tx_pin;
    logic [4:0] tx_cnt;
    logic xck;
    logic xck_oe;
    logic [2:0] rx_sync;
    scc_rx_state_type rx_state;
    logic [8:0] rx_shift;
    logic [3:0] rx_bit;
    logic rx_par;
    logic [4:0] rx_cnt;
    logic [8:0] rx_buf;
    logic rx_done;
    logic frame_err;
    logic overrun;
    logic parity_err;
    logic irq_rx;
    logic irq_tx;
    logic irq_empty;
  } scc_state_type;

  scc_state_type s_q;
  scc_state_type s_d;

  logic tick;
  logic sync_mode;
  logic [4:0] os;
  logic [3:0] nbits;
  logic [8:0] mask;
  logic tx_step;
  logic rx_step;
  logic rxd;
  logic rxd_stable;
  logic acc;
  logic cap;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic we;

  // Number of data bits from the size code
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'b000: char_bits = 4'h5;
      3'b001: char_bits = 4'h6;
      3'b010: char_bits = 4'h7;
      3'b011: char_bits = 4'h8;
      3'b111: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  scc_baud_gen #(
    .DIV_WIDTH(12)
  ) u_baud (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .divisor({s_q.div_high, s_q.div_low}),
    .reload(s_q.reload),
    .tick(tick)
  );

  always_comb begin
    sync_mode = s_q.frame[`SCC_FMT_SYNC];
    if (sync_mode) begin
      os = `SCC_OS_SYNC;
    end else if (s_q.double_speed) begin
      os = `SCC_OS_DOUBLE;
    end else begin
      os = `SCC_OS_NORMAL;
    end
    nbits = char_bits({s_q.size_high, s_q.frame[`SCC_FMT_SIZE_HI:`SCC_FMT_SIZE_LO]});
    mask = 9'h1FF >> (4'h9 - nbits);
    rxd = s_q.rx_sync[2];
    rxd_stable = (s_q.rx_sync[2] == s_q.rx_sync[1]);
    // Sync mode: change on one edge, sample on the other
    if (sync_mode) begin
      tx_step = tick && (s_q.xck == s_q.frame[`SCC_FMT_POL]);
      rx_step = tick && (s_q.xck != s_q.frame[`SCC_FMT_POL]);
    end else begin
      tx_step = tick && (s_q.tx_cnt == os - 5'd1);
      rx_step = tick && (s_q.rx_cnt == os - 5'd1);
    end
    cap = (av_req.read || av_req.write) && s_q.wait_q;
    acc = (av_req.read || av_req.write) && !s_q.wait_q;
    we = acc && av_req.write && av_req.byteenable[0];
    wbyte = av_req.writedata[7:0];
    rbyte = 8'h00;
    case (av_req.address)
      `SCC_OFF_STATUS_A: begin
        rbyte = {s_q.rx_done, s_q.tx_done, s_q.tx_empty, s_q.frame_err, s_q.overrun, s_q.parity_err,
                 s_q.double_speed, 1'b0};
      end
      `SCC_OFF_CONTROL_B: begin
        rbyte = {s_q.rx_irq_en, s_q.tx_irq_en, s_q.empty_irq_en, s_q.rx_en, s_q.tx_en_wr, s_q.size_high,
                 s_q.rx_buf[8], s_q.tx_ninth};
      end
      `SCC_OFF_FRAME: begin
        rbyte = {1'b0, s_q.frame[6:0]};
      end
      `SCC_OFF_DIV_HIGH: begin
        rbyte = {4'h0, s_q.div_high};
      end
      `SCC_OFF_DIV_LOW: begin
        rbyte = s_q.div_low;
      end
      `SCC_OFF_DATA: begin
        rbyte = s_q.rx_buf[7:0];
      end
      default: begin
        rbyte = 8'h00;
      end
    endcase

    s_d = s_q;
    s_d.reload = 1'b0;
    s_d.rx_sync = {s_q.rx_sync[1:0], serial_rx_pin};

    // Bus slave: one wait cycle, then the access
    s_d.wait_q = !cap;
    if (cap) begin
      s_d.rdata = {24'h000000, rbyte};
      s_d.rd_took = av_req.read && (av_req.address == `SCC_OFF_DATA) && s_q.rx_done;
    end
    if (we) begin
      case (av_req.address)
        `SCC_OFF_STATUS_A: begin
          s_d.double_speed = wbyte[`SCC_STA_DOUBLE];
          if (wbyte[`SCC_STA_TX_DONE]) begin
            s_d.tx_done = 1'b0;
          end
        end
        `SCC_OFF_CONTROL_B: begin
          s_d.rx_irq_en = wbyte[`SCC_CTL_RX_IRQ_EN];
          s_d.tx_irq_en = wbyte[`SCC_CTL_TX_IRQ_EN];
          s_d.empty_irq_en = wbyte[`SCC_CTL_EMPTY_IRQ_EN];
          s_d.rx_en = wbyte[`SCC_CTL_RX_EN];
          s_d.tx_en_wr = wbyte[`SCC_CTL_TX_EN];
          s_d.size_high = wbyte[`SCC_CTL_SIZE_HIGH];
          s_d.tx_ninth = wbyte[`SCC_CTL_TX_NINTH];
        end
        `SCC_OFF_FRAME: begin
          s_d.frame = {1'b0, wbyte[6:0]};
        end
        `SCC_OFF_DIV_HIGH: begin
          s_d.div_high = wbyte[3:0];
        end
        `SCC_OFF_DIV_LOW: begin
          s_d.div_low = wbyte;
          s_d.reload = 1'b1;
        end
        `SCC_OFF_DATA: begin
          // Writes while the buffer is full are dropped
          if (s_q.tx_empty) begin
            s_d.tx_buf = {s_q.tx_ninth, wbyte};
            s_d.tx_empty = 1'b0;
          end
        end
        default: begin
          s_d.rx_irq_en = s_q.rx_irq_en;
        end
      endcase
    end
    if (acc && av_req.read && s_q.rd_took) begin
      s_d.rx_done = 1'b0;
      s_d.frame_err = 1'b0;
      s_d.overrun = 1'b0;
      s_d.parity_err = 1'b0;
    end

    // Transmit enable takes effect at once, disable only once drained
    if (s_d.tx_en_wr) begin
      s_d.tx_en = 1'b1;
    end else if (s_q.tx_state == SCC_TX_IDLE && s_q.tx_empty) begin
      s_d.tx_en = 1'b0;
    end

    // Transfer clock runs in sync mode while either side is on
    s_d.xck_oe = sync_mode && (s_q.tx_en || s_q.rx_en);
    if (tick && sync_mode) begin
      s_d.xck = !s_q.xck;
    end else if (!sync_mode) begin
      s_d.xck = s_q.frame[`SCC_FMT_POL];
    end
    if (tick) begin
      s_d.tx_cnt = (s_q.tx_cnt >= os - 5'd1) ? 5'd0 : s_q.tx_cnt + 5'd1;
    end

    // Transmitter
    if (!s_q.tx_en) begin
      s_d.tx_state = SCC_TX_IDLE;
      s_d.tx_pin = 1'b1;
    end else if (tx_step) begin
      case (s_q.tx_state)
        SCC_TX_IDLE, SCC_TX_DONE: begin
          if (!s_q.tx_empty) begin
            s_d.tx_shift = s_q.tx_buf & mask;
            s_d.tx_par = (^(s_q.tx_buf & mask)) ^ s_q.frame[`SCC_FMT_PAR_LO];
            s_d.tx_empty = 1'b1;
            s_d.tx_pin = 1'b0;
            s_d.tx_bit = 4'h0;
            s_d.tx_state = SCC_TX_DATA;
          end else begin
            if (s_q.tx_state == SCC_TX_DONE) begin
              s_d.tx_done = 1'b1;
            end
            s_d.tx_state = SCC_TX_IDLE;
          end
        end
        SCC_TX_DATA: begin
          s_d.tx_pin = s_q.tx_shift[s_q.tx_bit];
          s_d.tx_bit = s_q.tx_bit + 4'h1;
          if (s_q.tx_bit == nbits - 4'h1) begin
            s_d.tx_state = s_q.frame[`SCC_FMT_PAR_HI] ? SCC_TX_PAR : SCC_TX_STOP1;
          end
        end
        SCC_TX_PAR: begin
          s_d.tx_pin = s_q.tx_par;
          s_d.tx_state = SCC_TX_STOP1;
        end
        SCC_TX_STOP1: begin
          s_d.tx_pin = 1'b1;
          s_d.tx_state = s_q.frame[`SCC_FMT_STOP] ? SCC_TX_STOP2 : SCC_TX_DONE;
        end
        SCC_TX_STOP2: begin
          s_d.tx_pin = 1'b1;
          s_d.tx_state = SCC_TX_DONE;
        end
        default: begin
          s_d.tx_state = SCC_TX_IDLE;
        end
      endcase
    end

    // Receiver
    if (tick) begin
      s_d.rx_cnt = (s_q.rx_cnt >= os - 5'd1) ? 5'd0 : s_q.rx_cnt + 5'd1;
    end
    if (!s_q.rx_en) begin
      s_d.rx_state = SCC_RX_IDLE;
      s_d.rx_done = 1'b0;
      s_d.frame_err = 1'b0;
      s_d.overrun = 1'b0;
      s_d.parity_err = 1'b0;
    end else begin
      case (s_q.rx_state)
        SCC_RX_IDLE: begin
          s_d.rx_shift = 9'h000;
          s_d.rx_bit = 4'h0;
          if (rxd_stable && !rxd) begin
            if (sync_mode && rx_step) begin
              s_d.rx_state = SCC_RX_DATA;
            end else if (!sync_mode && tick) begin
              s_d.rx_cnt = 5'd0;
              s_d.rx_state = SCC_RX_START;
            end
          end
        end
        SCC_RX_START: begin
          // Check the start bit again at its middle
          if (tick && s_q.rx_cnt == (os >> 1) - 5'd1) begin
            s_d.rx_cnt = 5'd0;
            s_d.rx_state = rxd ? SCC_RX_IDLE : SCC_RX_DATA;
          end
        end
        SCC_RX_DATA: begin
          if (rx_step) begin
            s_d.rx_shift[s_q.rx_bit] = rxd;
            s_d.rx_bit = s_q.rx_bit + 4'h1;
            if (s_q.rx_bit == nbits - 4'h1) begin
              s_d.rx_state = s_q.frame[`SCC_FMT_PAR_HI] ? SCC_RX_PAR : SCC_RX_STOP;
            end
          end
        end
        SCC_RX_PAR: begin
          if (rx_step) begin
            s_d.rx_par = rxd;
            s_d.rx_state = SCC_RX_STOP;
          end
        end
        SCC_RX_STOP: begin
          // Only the first stop bit is checked
          if (rx_step) begin
            s_d.rx_state = SCC_RX_IDLE;
            if (s_d.rx_done) begin
              s_d.overrun = 1'b1;
            end else begin
              s_d.rx_buf = s_q.rx_shift;
              s_d.rx_done = 1'b1;
              s_d.frame_err = !rxd;
              s_d.parity_err = s_q.frame[`SCC_FMT_PAR_HI] &&
                               (s_q.rx_par != ((^s_q.rx_shift) ^ s_q.frame[`SCC_FMT_PAR_LO]));
            end
          end
        end
        default: begin
          s_d.rx_state = SCC_RX_IDLE;
        end
      endcase
    end

    s_d.irq_rx = s_q.rx_irq_en && global_irq_flag && s_q.rx_done;
    s_d.irq_tx = s_q.tx_irq_en && global_irq_flag && s_q.tx_done;
    s_d.irq_empty = s_q.empty_irq_en && global_irq_flag && s_q.tx_empty;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.wait_q <= 1'b1;
      s_q.frame <= `SCC_RST_FRAME;
      s_q.div_high <= `SCC_RST_DIV_HIGH;
      s_q.div_low <= `SCC_RST_DIV_LOW;
      s_q.tx_empty <= 1'b1;
      s_q.tx_pin <= 1'b1;
      s_q.rx_sync <= 3'h7;
      s_q.tx_state <= SCC_TX_IDLE;
      s_q.rx_state <= SCC_RX_IDLE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign av_rsp.readdata = s_q.rdata;
  assign av_rsp.waitrequest = s_q.wait_q;
  assign rx_done_irq = s_q.irq_rx;
  assign tx_done_irq = s_q.irq_tx;
  assign buffer_empty_irq = s_q.irq_empty;
  assign serial_rx_takeover = s_q.rx_en;
  assign serial_tx_out = s_q.tx_pin;
  assign serial_tx_oe = s_q.tx_en;
  assign transfer_clock_out = s_q.xck;
  assign transfer_clock_oe = s_q.xck_oe;

endmodule

// [test/scc_chk_assertions.sv]
// Port-level assertion checker for the serial port channel
`timescale 1ns/100ps
`include "scc_consts.svh"
module scc_chk
  import scc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  // Bus and global flag
  input wire scc_av_req_type av_req,
  input wire scc_av_rsp_type av_rsp,
  input wire logic global_irq_flag,
  // Watched outputs
  input wire logic rx_done_irq,
  input wire logic tx_done_irq,
  input wire logic serial_rx_takeover,
  input wire logic serial_tx_out,
  input wire logic serial_tx_oe,
  input wire logic transfer_clock_oe
);
  logic ctl_wr;
  assign ctl_wr = av_req.write && !av_rsp.waitrequest && av_req.address == `SCC_OFF_CONTROL_B;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence s_bus_wait;
    ce && (av_req.read || av_req.write) && av_rsp.waitrequest;
  endsequence
  sequence s_ctl_recent;
    $past(ctl_wr, 1) || $past(ctl_wr, 2) || $past(ctl_wr, 3);
  endsequence
  sequence s_low_run;
    !serial_tx_out [*8];
  endsequence
  chk_rx_irq_gate: assert property (rx_done_irq |-> $past(global_irq_flag))
    else $error("receive interrupt without global flag");
  chk_tx_irq_gate: assert property (tx_done_irq |-> $past(global_irq_flag))
    else $error("transmit interrupt without global flag");
  chk_bus_one_wait: assert property (s_bus_wait ##1 ce |-> !av_rsp.waitrequest)
    else $error("bus answer not after one wait cycle");
  chk_bus_ack_pulse: assert property (!av_rsp.waitrequest |=> av_rsp.waitrequest)
    else $error("bus answer held too long");
  chk_rx_take_cause: assert property ($changed(serial_rx_takeover) |-> s_ctl_recent)
    else $error("receive pin ownership changed without control write");
  chk_tx_take_cause: assert property ($rose(serial_tx_oe) |-> s_ctl_recent)
    else $error("transmit pin taken without control write");
  chk_tx_keep_pin: assert property (!serial_tx_out |=> serial_tx_oe)
    else $error("transmit pin released in mid frame");
  chk_bit_min_len: assert property ($fell(serial_tx_out) && !transfer_clock_oe |-> s_low_run)
    else $error("transmitted low bit shorter than eight clocks");
endmodule

bind scc_top scc_chk u_scc_chk (.clock(clock), .resetn(resetn), .ce(ce), .av_req(av_req), .av_rsp(av_rsp),
  .global_irq_flag(global_irq_flag), .rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq),
  .serial_rx_takeover(serial_rx_takeover), .serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe),
  .transfer_clock_oe(transfer_clock_oe));

// [test/scc_remote.sv]
// Remote transceiver model: decodes the transmit line, sends frames on the receive line
`timescale 1ns/100ps
module scc_remote (
  // Clock and frame setup
  input wire logic clock,
  input wire logic [3:0] n_bits,
  input wire logic [1:0] par_mode,
  input wire logic [4:0] bit_clks,
  // Line from the block
  input wire logic line_in,
  output logic [9:0] got,
  output logic got_stb,
  // Line to the block
  input wire logic send_stb,
  input wire logic send_bad,
  input wire logic [8:0] send_data,
  output logic line_out
);
  logic rp;
  logic sp;
  initial begin
    got_stb = 1'b0;
    forever begin
      @(negedge line_in);
      repeat (bit_clks / 2) @(posedge clock);
      got = 10'h000;
      rp = par_mode[0];
      for (int i = 0; i < n_bits; i++) begin
        repeat (bit_clks) @(posedge clock);
        got[i] = line_in;
        rp ^= line_in;
      end
      if (par_mode[1]) begin
        repeat (bit_clks) @(posedge clock);
        rp ^= line_in;
      end
      repeat (bit_clks) @(posedge clock);
      // Only the first stop bit is judged
      got[9] = (par_mode[1] && rp) || !line_in;
      got_stb = 1'b1;
      @(posedge clock);
      got_stb = 1'b0;
    end
  end
  initial begin
    line_out <= 1'b1;
    forever begin
      @(posedge send_stb);
      // Bad parity only when the bench asks for it
      sp = par_mode[0] ^ send_bad;
      line_out <= 1'b0;
      for (int i = 0; i < n_bits; i++) begin
        repeat (bit_clks) @(posedge clock);
        line_out <= send_data[i];
        sp ^= send_data[i];
      end
      if (par_mode[1]) begin
        repeat (bit_clks) @(posedge clock);
        line_out <= sp;
      end
      repeat (bit_clks) @(posedge clock);
      line_out <= 1'b1;
      repeat (bit_clks) @(posedge clock);
    end
  end
endmodule

// [test/tb_top.sv]
// Self-checking testbench for the serial port channel
`timescale 1ns/100ps
`include "scc_consts.svh"
module tb_top
  import scc_pkg::*;
;
  logic clock, resetn, ce, global_irq_flag, rx_pin, send_stb, send_bad, got_stb;
  logic rx_done_irq, tx_done_irq, buffer_empty_irq, rx_take, tx_out, tx_oe, xck, xck_oe;
  scc_av_req_type av_req;
  scc_av_rsp_type av_rsp;
  logic [3:0] n_bits;
  logic [1:0] par_mode;
  logic [4:0] bit_clks;
  logic [8:0] send_data, d9;
  logic [9:0] got;
  logic [6:0] cfg;
  logic [7:0] exp_rd[$];
  logic [9:0] exp_ch[$];
  int n_errors, cmp_count, nb;
  integer seed;
  logic tx_prev;
  // Size code, parity, stop select, double speed
  localparam logic [6:0] TX_TAB [5] = '{7'b0001000, 7'b0011111, 7'b0100000, 7'b0111011, 7'b1111100};

  scc_top u_scc_top (.clock(clock), .resetn(resetn), .ce(ce), .av_req(av_req), .av_rsp(av_rsp),
    .global_irq_flag(global_irq_flag), .rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq),
    .buffer_empty_irq(buffer_empty_irq), .serial_rx_pin(rx_pin), .serial_rx_takeover(rx_take),
    .serial_tx_out(tx_out), .serial_tx_oe(tx_oe), .transfer_clock_out(xck), .transfer_clock_oe(xck_oe));
  scc_remote u_scc_remote (.clock(clock), .n_bits(n_bits), .par_mode(par_mode), .bit_clks(bit_clks),
    .line_in(tx_out), .got(got), .got_stb(got_stb), .send_stb(send_stb), .send_bad(send_bad),
    .send_data(send_data), .line_out(rx_pin));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [9:0] e, input logic [9:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    check(nm, {9'h000, e}, {9'h000, g});
  endtask

  task automatic bus(input logic rd, input logic [4:0] adr, input logic [7:0] wd);
    av_req.read <= rd;
    av_req.write <= !rd;
    av_req.address <= adr;
    av_req.writedata <= {24'h000000, wd};
    av_req.byteenable <= 4'hF;
    @(posedge clock);
    while (av_rsp.waitrequest) begin
      @(posedge clock);
    end
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [4:0] adr, input logic [7:0] wd);
    bus(1'b0, adr, wd);
  endtask

  task automatic rd(input logic [4:0] adr, input logic [7:0] e);
    exp_rd.push_back(e);
    bus(1'b1, adr, 8'h00);
  endtask

  task automatic wait_irq(input int w);
    logic [2:0] v;
    v = {buffer_empty_irq, tx_done_irq, rx_done_irq};
    while (v[w] !== 1'b1) begin
      @(posedge clock);
      v = {buffer_empty_irq, tx_done_irq, rx_done_irq};
    end
  endtask

  always @(posedge clock) begin
    if (av_req.read && !av_rsp.waitrequest) begin
      check("readdata", {2'b00, exp_rd.pop_front()}, {2'b00, av_rsp.readdata[7:0]});
    end
  end

  always @(posedge got_stb) begin
    check("line char", exp_ch.pop_front(), got);
  end

  // Sync data change must leave the transfer clock low (polarity one)
  always @(posedge clock) begin
    if (xck_oe && tx_out !== tx_prev) begin
      chk_bit("xck at data change", 1'b0, xck);
    end
    tx_prev <= tx_out;
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("watchdog expired");
    tally_and_finish;
  end

  initial begin
    seed = 32'h205059a8;
    av_req = '0;
    resetn = 1'b0;
    ce = 1'b1;
    global_irq_flag = 1'b0;
    {send_stb, send_bad, send_data} = '0;
    n_bits = 4'h8;
    par_mode = 2'h0;
    bit_clks = 5'h10;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(`SCC_OFF_STATUS_A, 8'h20);
    rd(`SCC_OFF_CONTROL_B, `SCC_RST_CONTROL_B);
    rd(`SCC_OFF_FRAME, `SCC_RST_FRAME);
    rd(`SCC_OFF_DIV_HIGH, 8'h00);
    rd(`SCC_OFF_DIV_LOW, `SCC_RST_DIV_LOW);
    rd(5'h18, 8'h00);
    wr(`SCC_OFF_DIV_HIGH, 8'h0A);
    wr(`SCC_OFF_DIV_LOW, 8'h35);
    rd(`SCC_OFF_DIV_HIGH, 8'h0A);
    rd(`SCC_OFF_DIV_LOW, 8'h35);
    wr(`SCC_OFF_DIV_HIGH, 8'h00);
    wr(`SCC_OFF_DIV_LOW, 8'h00);
    global_irq_flag <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      cfg = TX_TAB[k];
      nb = (cfg[6:4] == 3'b111) ? 9 : 5 + cfg[5:4];
      d9 = 9'($random(seed));
      n_bits <= nb[3:0];
      par_mode <= cfg[3:2];
      bit_clks <= cfg[0] ? 5'h08 : 5'h10;
      wr(`SCC_OFF_STATUS_A, {6'h00, cfg[0], 1'b0});
      wr(`SCC_OFF_FRAME, {2'b00, cfg[3:1], cfg[5:4], 1'b0});
      wr(`SCC_OFF_CONTROL_B, {5'b01001, cfg[6], 1'b0, d9[8]});
      exp_ch.push_back({1'b0, d9 & (9'h1FF >> (9 - nb))});
      wr(`SCC_OFF_DATA, d9[7:0]);
      if (k == 4) begin
        wr(`SCC_OFF_CONTROL_B, {5'b01000, cfg[6], 1'b0, d9[8]});
        chk_bit("tx_oe", 1'b1, tx_oe);
      end
      wait_irq(1);
      chk_bit("tx_done_irq", 1'b1, tx_done_irq);
      wr(`SCC_OFF_STATUS_A, 8'h40);
      repeat (2) @(posedge clock);
      chk_bit("tx_done_irq", 1'b0, tx_done_irq);
    end
    chk_bit("tx_oe", 1'b0, tx_oe);
    n_bits <= 4'h9;
    par_mode <= 2'b10;
    bit_clks <= 5'h10;
    wr(`SCC_OFF_FRAME, 8'h26);
    wr(`SCC_OFF_CONTROL_B, 8'h94);
    for (int j = 0; j < 2; j++) begin
      send_data <= 9'($random(seed));
      send_bad <= j[0];
      send_stb <= 1'b1;
      @(posedge clock);
      send_stb <= 1'b0;
      wait_irq(0);
      chk_bit("rx_done_irq", 1'b1, rx_done_irq);
      chk_bit("rx_take", 1'b1, rx_take);
      rd(`SCC_OFF_STATUS_A, {5'b10100, j[0], 2'b00});
      rd(`SCC_OFF_CONTROL_B, {6'b100101, send_data[8], 1'b0});
      if (j == 0) begin
        rd(`SCC_OFF_DATA, send_data[7:0]);
      end else begin
        wr(`SCC_OFF_CONTROL_B, 8'h84);
        repeat (2) @(posedge clock);
        chk_bit("rx_take", 1'b0, rx_take);
      end
      rd(`SCC_OFF_STATUS_A, 8'h20);
    end
    wr(`SCC_OFF_CONTROL_B, 8'h28);
    wait_irq(2);
    chk_bit("empty_irq", 1'b1, buffer_empty_irq);
    // Clock enable low must freeze the interrupt output
    ce <= 1'b0;
    global_irq_flag <= 1'b0;
    repeat (3) @(posedge clock);
    chk_bit("empty_irq", 1'b1, buffer_empty_irq);
    ce <= 1'b1;
    repeat (3) @(posedge clock);
    chk_bit("empty_irq", 1'b0, buffer_empty_irq);
    n_bits <= 4'h5;
    par_mode <= 2'b00;
    bit_clks <= 5'h02;
    wr(`SCC_OFF_FRAME, 8'h41);
    repeat (2) @(posedge clock);
    chk_bit("xck_oe", 1'b1, xck_oe);
    d9 = 9'($random(seed));
    exp_ch.push_back({5'h00, d9[4:0]});
    wr(`SCC_OFF_DATA, d9[7:0]);
    @(negedge got_stb);
    wr(`SCC_OFF_FRAME, 8'h06);
    repeat (2) @(posedge clock);
    chk_bit("xck_oe", 1'b0, xck_oe);
    chk_bit("xck", 1'b0, xck);
    tally_and_finish;
  end
endmodule
